/* File: logic/gpl_top.sv */
// Purpose: Generic packet path between packet DMA and the link encoder
// Assumes: Link strobe and monitor inputs come from logic on sys_clk
// Notes:   One word leaves per strobe; the FIFO absorbs DMA bursts
//
// Operation
// - Generic data rides control slots beside antenna
// - Without antenna stream, generic may use carrier slots
// - OBSAI control path: one slot per 21
// - OBSAI packets are nonzero multiples of 16 bytes
// - CPRI control words: 1/16, from row pointer
// - CPRI carrier slots always use 4B/5B delimiting
// - 19-byte messages, one comma per 400 bytes
// - No timestamp, terminal count or timing checks
// - CPRI starvation truncates packet, flags no data
// - OBSAI starvation held off, packets stay whole
// - Priority select: antenna first or equal share
// - 24-bit wrapping end of packet counter
// - DIO mode counts ingress bursts only
// - Module errors set origin bit and interrupt
// - Encoder flags empty buffer at transmit time
// - Encoder flags symbol index mismatch
// - Flag missing free receive descriptor
// - Flag line code violation and sync loss
`timescale 1ns/1ps

// Packet FIFO; registered ready so back-pressure is a flop
module gpl_fifo #(
  parameter int W     = 34,
  parameter int DEPTH = 8
) (
  input  wire logic                       sys_clk,
  input  wire logic                       resetn,
  input  wire logic                       ce,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [W-1:0]               in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [W-1:0]                    out_data,
  output logic [$clog2(DEPTH):0]          count
);
  localparam int AW = $clog2(DEPTH);
  // Whole FIFO state
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    rdy;
  } gpl_fifo_st_s;
  localparam gpl_fifo_st_s RST = '{mem: '0, wp: '0, rp: '0, cnt: '0,
                                   rdy: 1'b1};
  gpl_fifo_st_s st_ff;   // Registered state
  gpl_fifo_st_s nxt_st;  // Next state
  logic         push;    // Word accepted
  logic         pop;     // Word drained

  // Push and pop bookkeeping
  always_comb begin
    nxt_st = st_ff;
    push   = in_valid && st_ff.rdy;
    pop    = out_ready && (st_ff.cnt != '0);
    if (push) begin
      nxt_st.mem[st_ff.wp] = in_data;
      nxt_st.wp            = AW'(st_ff.wp + 1'b1);
    end
    if (pop) begin
      nxt_st.rp = AW'(st_ff.rp + 1'b1);
    end
    nxt_st.cnt = (AW+1)'(st_ff.cnt + {{AW{1'b0}}, push}
                 - {{AW{1'b0}}, pop});
    // Ready from next count: honest full, no combinational path
    nxt_st.rdy = (nxt_st.cnt < (AW+1)'(DEPTH));
  end

  // State register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= RST;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign in_ready  = st_ff.rdy;
  assign out_valid = (st_ff.cnt != '0);
  assign out_data  = st_ff.mem[st_ff.rp];
  assign count     = st_ff.cnt;
endmodule : gpl_fifo

// Framer top: APB registers, slot scheduler, error aggregation
module gpl_top (
  input  wire logic                      sys_clk,
  input  wire logic                      resetn,
  input  wire logic                      ce,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      dma_valid,
  output logic                           dma_ready,
  input  wire gpl_pkg::gpl_pkt_s         dma_pkt,
  input  wire logic                      link_strobe,
  input  wire logic                      ant_valid,
  input  wire logic [31:0]               ant_data,
  output logic                           ant_ack,
  output gpl_pkg::gpl_link_s             link_out,
  input  wire logic [7:0]                sym_expected,
  input  wire logic                      ingress_eop,
  input  wire logic                      dio_ingress_burst,
  input  wire logic                      desc_needed,
  input  wire logic                      free_q_empty,
  input  wire logic                      lmon_code_viol,
  input  wire logic                      lmon_sync,
  input  wire logic [17:0]               mod_err_in,
  output logic                           err_irq
);
  // Whole block state
  typedef struct packed {
    gpl_pkg::gpl_ctrl_s  ctrl;
    logic [17:0]         origin;
    logic [5:0]          modsts;
    logic [23:0]         eop;
    logic [4:0]          slot;
    logic [1:0]          mword;
    logic [3:0]          wd;
    logic [5:0]          row;
    logic                msg_gen;
    logic                rr;
    gpl_pkg::gpl_tx_e    tx;
    logic [1:0]          pwords;
    logic                sync_d;
    gpl_pkg::gpl_link_s  link;
    logic                ant_ack;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
    logic                irq;
  } gpl_top_st_s;

  gpl_top_st_s        s;          // Registered state
  gpl_top_st_s        n;          // Next state
  gpl_pkg::gpl_pkt_s  f_pkt;      // FIFO head
  logic               f_valid;    // FIFO holds a word
  logic [3:0]         f_cnt;      // FIFO fill level
  logic               pop;        // Drain one FIFO word
  logic               have_msg;   // A whole OBSAI payload is buffered
  logic               ctrl_slot;  // Strobe is a control slot or word
  logic               comma;      // Strobe is the group comma
  logic               ant_slot;   // Strobe is a carrier slot
  logic               gen_slot;   // Generic may use this strobe
  logic               ant_want;   // Antenna stream asks for the slot
  logic               conflict;   // Both parties want one slot
  logic               gen_win;    // Generic wins arbitration
  logic               gen_take;   // Generic owns this strobe
  logic               acc;        // APB access phase
  logic               hit;        // Mapped address
  logic [31:0]        rd;         // Read mux
  logic [17:0]        clr_org;    // Origin bits cleared by software
  logic [5:0]         clr_sts;    // Status bits cleared by software
  logic [5:0]         se;         // Status bits set this cycle
  logic [17:0]        org_set;    // Origin bits set this cycle

  // Packet buffer in the DMA path
  gpl_fifo #(.W($bits(gpl_pkg::gpl_pkt_s)), .DEPTH(gpl_pkg::FIFO_DEPTH))
  u_fifo (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .ce        (ce),
    .in_valid  (dma_valid),
    .in_ready  (dma_ready),
    .in_data   (dma_pkt),
    .out_valid (f_valid),
    .out_ready (pop),
    .out_data  (f_pkt),
    .count     (f_cnt)
  );

  // Slot classification for the current strobe
  always_comb begin
    have_msg  = (f_cnt >= gpl_pkg::MSG_WORDS);
    ctrl_slot = s.ctrl.cpri ? (s.wd == 4'h0) : (s.slot == 5'h00);
    comma     = !s.ctrl.cpri && (s.slot == gpl_pkg::OBS_COMMA);
    ant_slot  = !ctrl_slot && !comma;
    // Control path keeps carrier slots for antenna data
    if (s.ctrl.axc) begin
      gen_slot = ant_slot;
    end else if (s.ctrl.cpri) begin
      gen_slot = ctrl_slot && (s.row >= s.ctrl.row_ptr);
    end else begin
      gen_slot = ctrl_slot;
    end
    ant_want = s.ctrl.stream && ant_valid && ant_slot;
    conflict = s.ctrl.axc && gen_slot && ant_want && f_valid;
    // Zero: antenna first; one: alternate fairly
    if (conflict) begin
      gen_win = s.ctrl.scheduler_priority_select && s.rr;
    end else begin
      gen_win = 1'b1;
    end
    // No timestamp or terminal count gates generic words
    if (!s.ctrl.en || (s.tx == gpl_pkg::GPL_TX_DROP)) begin
      gen_take = 1'b0;
    end else if (s.ctrl.cpri) begin
      gen_take = gen_slot && gen_win;
    end else if (s.mword == 2'h0) begin
      // Start a message only with a full payload on hand
      gen_take = gen_slot && gen_win && have_msg;
    end else begin
      gen_take = s.msg_gen;
    end
  end

  // Next state: bus, scheduler, counters, errors
  always_comb begin
    n         = s;
    pop       = 1'b0;
    se        = '0;
    clr_org   = '0;
    clr_sts   = '0;
    n.link    = '0;
    n.ant_ack = 1'b0;
    acc       = psel && penable;
    hit       = 1'b1;
    rd        = 32'h0;
    // Register read mux; reserved bits read zero
    unique case (paddr)
      gpl_pkg::ADDR_CTRL:   rd = {18'h0, s.ctrl};
      gpl_pkg::ADDR_STATUS: rd = {25'h0, s.sync_d, f_cnt, s.tx};
      gpl_pkg::ADDR_EOP:    rd = {8'h0, s.eop};
      gpl_pkg::ADDR_ORIGIN: rd = {14'h0, s.origin};
      gpl_pkg::ADDR_MODSTS: rd = {26'h0, s.modsts};
      default:              hit = 1'b0;
    endcase
    // APB: one wait state, write lands on the completing edge
    if (acc && !s.pready) begin
      n.pready  = 1'b1;
      n.prdata  = rd;
      n.pslverr = !hit;
    end else if (acc) begin
      n.pready  = 1'b0;
      n.pslverr = 1'b0;
      if (pwrite && (paddr == gpl_pkg::ADDR_CTRL)) begin
        n.ctrl      = gpl_pkg::gpl_ctrl_s'(pwdata[13:0]);
        n.ctrl.rsvd = 1'b0;
      end
      if (pwrite && (paddr == gpl_pkg::ADDR_ORIGIN)) begin
        clr_org = pwdata[17:0];
      end
      if (pwrite && (paddr == gpl_pkg::ADDR_MODSTS)) begin
        clr_sts = pwdata[5:0];
      end
    end
    // Drop the remainder of a truncated packet
    if ((s.tx == gpl_pkg::GPL_TX_DROP) && f_valid) begin
      pop = 1'b1;
      if (f_pkt.eop) begin
        n.tx = gpl_pkg::GPL_TX_IDLE;
      end
    end
    // One link word per strobe
    if (link_strobe) begin
      if (conflict) begin
        n.rr = !s.rr;
      end
      if (!s.ctrl.cpri && (s.mword == 2'h0)) begin
        n.msg_gen = gen_take;
        // Packet waiting but payload short: slot skipped
        if (gen_slot && gen_win && s.ctrl.en && !have_msg
            && (s.tx == gpl_pkg::GPL_TX_SEND)) begin
          se[gpl_pkg::E_NODATA] = 1'b1;
        end
      end
      if (comma) begin
        n.link.valid = 1'b1;
        n.link.kind  = gpl_pkg::GPL_K_COMMA;
      end else if (gen_take && f_valid) begin
        pop               = 1'b1;
        n.link.valid      = 1'b1;
        n.link.kind       = gpl_pkg::GPL_K_GEN;
        n.link.sop        = f_pkt.sop;
        n.link.eop        = f_pkt.eop;
        n.link.data       = f_pkt.data;
        // Carrier slots in CPRI never offer NULL delimiting
        n.link.delim_null = s.ctrl.cpri && !s.ctrl.axc
                            && s.ctrl.null_delim;
        n.pwords          = f_pkt.sop ? 2'h1 : 2'(s.pwords + 2'h1);
        if (f_pkt.sop && (f_pkt.data[7:0] != sym_expected)) begin
          se[gpl_pkg::E_SYMBOL] = 1'b1;
        end
        // OBSAI length must close on a 16-byte boundary
        if (f_pkt.eop && !s.ctrl.cpri
            && ((f_pkt.sop ? 2'h0 : s.pwords) != gpl_pkg::MSG_LAST)) begin
          se[gpl_pkg::E_LENGTH] = 1'b1;
        end
        n.tx = f_pkt.eop ? gpl_pkg::GPL_TX_IDLE : gpl_pkg::GPL_TX_SEND;
      end else if (gen_take && (s.tx == gpl_pkg::GPL_TX_SEND)) begin
        // DMA late in CPRI: close packet with a plain end
        n.link.valid          = 1'b1;
        n.link.kind           = gpl_pkg::GPL_K_GEN;
        n.link.eop            = 1'b1;
        n.link.delim_null     = s.ctrl.cpri && !s.ctrl.axc
                                && s.ctrl.null_delim;
        n.tx                  = gpl_pkg::GPL_TX_DROP;
        se[gpl_pkg::E_NODATA] = 1'b1;
      end else if (ant_want) begin
        n.link.valid = 1'b1;
        n.link.kind  = gpl_pkg::GPL_K_ANT;
        n.link.data  = ant_data;
        n.ant_ack    = 1'b1;
      end
      // Frame position counters
      if (s.ctrl.cpri) begin
        n.wd = 4'(s.wd + 4'h1);
        if (s.wd == gpl_pkg::CPRI_LAST_WD) begin
          n.row = 6'(s.row + 6'h01);
        end
      end else if (comma) begin
        n.slot  = 5'h00;
        n.mword = 2'h0;
      end else begin
        n.mword = 2'(s.mword + 2'h1);
        if (s.mword == gpl_pkg::MSG_LAST) begin
          n.slot = 5'(s.slot + 5'h01);
        end
      end
    end
    // End of packet counter, wraps at 24 bits
    if (s.ctrl.dio ? dio_ingress_burst : ingress_eop) begin
      n.eop = 24'(s.eop + 24'h000001);
    end
    // Link monitor and descriptor errors
    se[gpl_pkg::E_DESC] = desc_needed && free_q_empty;
    se[gpl_pkg::E_LCV]  = lmon_code_viol;
    se[gpl_pkg::E_SYNC] = s.sync_d && !lmon_sync;
    n.sync_d            = lmon_sync;
    // Set wins over a same-cycle software clear
    n.modsts = (s.modsts & ~clr_sts) | se;
    org_set  = mod_err_in;
    org_set[gpl_pkg::ORG_ENC] = mod_err_in[gpl_pkg::ORG_ENC]
                                | (|se[2:0]);
    org_set[gpl_pkg::ORG_DMA] = mod_err_in[gpl_pkg::ORG_DMA]
                                | se[gpl_pkg::E_DESC];
    org_set[gpl_pkg::ORG_LMON] = mod_err_in[gpl_pkg::ORG_LMON]
                                | (|se[5:4]);
    n.origin = (s.origin & ~clr_org) | org_set;
    n.irq    = |n.origin;
  end

  // Single state register, frozen while ce is low
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s      <= '0;
      s.ctrl <= gpl_pkg::gpl_ctrl_s'(gpl_pkg::CTRL_RST);
    end else if (ce) begin
      s <= n;
    end
  end

  // Outputs straight from flops
  assign prdata   = s.prdata;
  assign pready   = s.pready;
  assign pslverr  = s.pslverr;
  assign ant_ack  = s.ant_ack;
  assign link_out = s.link;
  assign err_irq  = s.irq;

  // Checks beside the logic
  chk_obs_ctrl_slot: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (ce && link_strobe && !s.ctrl.cpri && !s.ctrl.axc && gen_take)
      |-> (s.slot == 5'h00))
    else $error("generic word outside OBSAI control slot");
  chk_cpri_ctrl_word: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (ce && link_strobe && s.ctrl.cpri && !s.ctrl.axc && gen_take)
      |-> ((s.wd == 4'h0) && (s.row >= s.ctrl.row_ptr)))
    else $error("generic word outside CPRI control rows");
  chk_axc_delim: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (link_out.valid && (link_out.kind == gpl_pkg::GPL_K_GEN)
     && $past(s.ctrl.cpri) && $past(s.ctrl.axc)) |-> !link_out.delim_null)
    else $error("NULL delimiter on CPRI carrier slot");
  chk_comma_slot: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (ce && link_strobe && !s.ctrl.cpri && (s.slot == gpl_pkg::OBS_COMMA))
      |=> (link_out.valid && (link_out.kind == gpl_pkg::GPL_K_COMMA)))
    else $error("missing comma at group end");
  chk_cpri_trunc: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (ce && link_strobe && s.ctrl.cpri && gen_take && !f_valid
     && (s.tx == gpl_pkg::GPL_TX_SEND))
      |=> ((s.tx == gpl_pkg::GPL_TX_DROP) && link_out.eop
           && s.modsts[gpl_pkg::E_NODATA]))
    else $error("starved CPRI packet not truncated");
  chk_eop_count: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (ce && ingress_eop && !s.ctrl.dio)
      |=> (s.eop == 24'($past(s.eop) + 24'h000001)))
    else $error("end of packet count did not advance");
  chk_dio_count: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (ce && s.ctrl.dio && !dio_ingress_burst) |=> $stable(s.eop))
    else $error("end of packet count moved without burst");
  chk_origin_irq: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (ce && (|mod_err_in)) |=> (err_irq && (|s.origin)))
    else $error("module error did not raise interrupt");
  chk_desc_starve: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (ce && desc_needed && free_q_empty)
      |=> (s.modsts[gpl_pkg::E_DESC] && s.origin[gpl_pkg::ORG_DMA]))
    else $error("descriptor starvation not flagged");
endmodule : gpl_top

/* File: logic/gpl_pkg.sv */
// Purpose: Shared constants and types for the generic packet link path
// Assumes: One system clock; registers reached over APB, 32-bit words
// Notes:   Slot and word counts describe OBSAI groups and CPRI frames
package gpl_pkg;
  // Register byte offsets
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_STATUS  = 8'h04;
  localparam logic [7:0]  ADDR_EOP     = 8'h08;
  localparam logic [7:0]  ADDR_ORIGIN  = 8'h0c;
  localparam logic [7:0]  ADDR_MODSTS  = 8'h10;
  // Control register width and reset value
  localparam int          CTRL_W       = 14;
  localparam logic [13:0] CTRL_RST     = 14'h0000;
  // OBSAI framing: 19-byte message, 16-byte payload, 400-byte group
  localparam int          MSG_BYTES    = 19;
  localparam int          PAY_BYTES    = 16;
  localparam int          GROUP_BYTES  = 400;
  // Messages per group; the one byte left over is the comma
  localparam int          OBS_MSGS     = (GROUP_BYTES - 1) / MSG_BYTES;
  localparam logic [4:0]  OBS_COMMA    = 5'(OBS_MSGS);
  localparam logic [1:0]  MSG_LAST     = 2'(PAY_BYTES / 4 - 1);
  localparam logic [3:0]  MSG_WORDS    = 4'(PAY_BYTES / 4);
  // CPRI framing: 16 words per basic frame, 64 control word rows
  localparam logic [3:0]  CPRI_LAST_WD = 4'hf;
  localparam logic [5:0]  CW_LAST_ROW  = 6'h3f;
  // Module error status bit positions
  localparam int          E_NODATA     = 0;
  localparam int          E_SYMBOL     = 1;
  localparam int          E_LENGTH     = 2;
  localparam int          E_DESC       = 3;
  localparam int          E_LCV        = 4;
  localparam int          E_SYNC       = 5;
  localparam int          MSTS_W       = 6;
  // Error origin layout
  localparam int          N_MOD        = 18;
  localparam int          ORG_ENC      = 0;
  localparam int          ORG_DMA      = 1;
  localparam int          ORG_LMON     = 2;
  // Widths and depths
  localparam int          EOP_W        = 24;
  localparam int          DATA_W       = 32;
  localparam int          SYM_W        = 8;
  localparam int          FIFO_DEPTH   = 8;

  // Kind of word placed on the link
  typedef enum logic [1:0] {
    GPL_K_IDLE  = 2'h0,
    GPL_K_ANT   = 2'h1,
    GPL_K_GEN   = 2'h2,
    GPL_K_COMMA = 2'h3
  } gpl_kind_e;

  // Generic packet transmit state, Gray along idle-send-drop
  typedef enum logic [1:0] {
    GPL_TX_IDLE = 2'h0,
    GPL_TX_SEND = 2'h1,
    GPL_TX_DROP = 2'h3
  } gpl_tx_e;

  // Packet word from the DMA side
  typedef struct packed {
    logic        sop;
    logic        eop;
    logic [31:0] data;
  } gpl_pkt_s;

  // Word handed to the link encoder
  typedef struct packed {
    logic        valid;
    gpl_kind_e   kind;
    logic        sop;
    logic        eop;
    logic        delim_null;
    logic [31:0] data;
  } gpl_link_s;

  // Control register layout, bit 13 downward
  typedef struct packed {
    logic [5:0] row_ptr;
    logic       rsvd;
    logic       stream;
    logic       dio;
    logic       scheduler_priority_select;
    logic       null_delim;
    logic       axc;
    logic       cpri;
    logic       en;
  } gpl_ctrl_s;
endpackage : gpl_pkg

/* File: test/gpl_dma_model.sv */
// Purpose: Packet DMA stand-in that feeds the framer stream port
// Assumes: The caller keeps OBSAI lengths a whole number of 4 words
// Notes:   cut stops the feed early so that the encoder starves
`timescale 1ns/1ps
module gpl_dma_model (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic         dma_ready,
  input  wire logic         go,
  input  wire logic [7:0]   len,
  input  wire logic [7:0]   cut,
  output logic              dma_valid,
  output gpl_pkg::gpl_pkt_s dma_pkt
);
  logic [7:0] n;  // Words already taken
  logic [7:0] ni; // Index of the next word
  assign ni = n + 8'h01;
  // Offer words in order and hold each one until it is taken
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dma_valid <= 1'h0;
      dma_pkt   <= '0;
      n         <= 8'h00;
    end else if (go) begin // Start marker on the first word
      n         <= 8'h00;
      dma_valid <= 1'h1;
      dma_pkt   <= '{1'h1, len == 8'h01, 32'ha000_0000};
    end else if (dma_valid && dma_ready) begin
      n <= ni;
      if (ni == len || ni == cut) begin // Stop at the end or at the cut
        dma_valid    <= 1'h0;
        dma_pkt.data <= ~dma_pkt.data; // Released bus shows junk
      end else begin // End marker on the last word
        dma_pkt <= '{1'h0, ni == len - 8'h01, 32'ha000_0000 + 32'(ni)};
      end
    end
  end
endmodule : gpl_dma_model

/* File: test/gpl_top_tb_top.sv */
// Purpose: Self-checking bench for the generic packet framer
// Assumes: APB answers within 50 cycles; strobe every other cycle
// Notes:   Register rows run first, then event, error and stream cases
`timescale 1ns/1ps
module gpl_top_tb_top;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] x;
    logic        e;
  } gpl_row_s;
  logic        sys_clk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic        pwrite = 1'h0, link_strobe = 1'h0, go = 1'h0, run = 1'h0;
  logic        ant_valid = 1'h0, pready, pslverr, dma_valid, dma_ready;
  logic        ant_ack, err_irq, e;
  logic [7:0]  paddr = 8'h00, sym_expected = 8'h00, len = 8'h00, cut = 8'h00;
  logic [31:0] pwdata = 32'h0, ant_data = 32'h0, prdata, r;
  logic [22:0] ev = 23'h0; // Event pulses: eop, burst, desc, lcv, sync, mods
  gpl_pkg::gpl_pkt_s  dma_pkt;
  gpl_pkg::gpl_link_s link_out;
  gpl_pkg::gpl_link_s q[$]; // Generic words seen on the link
  int          bad_count = 0, check_count = 0, ants = 0, acks = 0;
  // Register rows: write, address, data, read expected, error expected
  gpl_row_s rows [8] = '{
    '{1'h0, 8'h00, 32'h0, 32'h0, 1'h0},
    '{1'h1, 8'h00, 32'hffff_ffff, 32'h0, 1'h0},
    '{1'h0, 8'h00, 32'h0, 32'h3f7f, 1'h0}, // Reserved bit stays 0
    '{1'h1, 8'h00, 32'h0, 32'h0, 1'h0},
    '{1'h0, 8'h04, 32'h0, 32'h40, 1'h0},   // Idle, empty, in sync
    '{1'h0, 8'h08, 32'h0, 32'h0, 1'h0},
    '{1'h0, 8'h14, 32'h0, 32'h0, 1'h1},    // Unmapped read
    '{1'h1, 8'h20, 32'h5, 32'h0, 1'h1}};   // Unmapped write
  always #4 sys_clk = ~sys_clk;
  // Strobe every other cycle while running; antenna data keeps moving
  always @(posedge sys_clk) begin
    link_strobe <= run & ~link_strobe;
    ant_data    <= ant_data + 32'h1;
  end
  // Collect what the framer puts on the link
  always @(posedge sys_clk) begin
    if (link_out.valid === 1'h1 && link_out.kind === gpl_pkg::GPL_K_GEN) begin
      q.push_back(link_out);
    end else if (link_out.valid === 1'h1) begin
      ants++;
    end
    // Every antenna word taken must be acknowledged once
    if (ant_ack === 1'h1) begin
      acks++;
    end
  end
  gpl_dma_model i_dma (.sys_clk(sys_clk), .resetn(resetn),
    .dma_ready(dma_ready), .go(go), .len(len), .cut(cut),
    .dma_valid(dma_valid), .dma_pkt(dma_pkt));
  gpl_top i_dut (.sys_clk(sys_clk), .resetn(resetn), .ce(1'h1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dma_valid(dma_valid), .dma_ready(dma_ready), .dma_pkt(dma_pkt),
    .link_strobe(link_strobe), .ant_valid(ant_valid), .ant_data(ant_data),
    .ant_ack(ant_ack), .link_out(link_out), .sym_expected(sym_expected),
    .ingress_eop(ev[0]), .dio_ingress_burst(ev[1]), .desc_needed(ev[2]),
    .free_q_empty(ev[2]), .lmon_code_viol(ev[3]), .lmon_sync(~ev[4]),
    .mod_err_in(ev[22:5]), .err_irq(err_irq));
  // Print the counts and the verdict, then stop
  task results;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'h1 && k < 50);
    r = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    if (k == 50) begin
      chk("apb_wait", 32'h0, 32'h1);
      results();
    end
  endtask : apb
  task automatic pulse(input logic [22:0] m);
    @(posedge sys_clk);
    ev <= m;
    @(posedge sys_clk);
    ev <= 23'h0;
  endtask : pulse
  // Bounded wait: FIFO full when f is set, else n generic words seen
  task automatic waitfor(input logic f, input int n);
    int k;
    for (k = 0; k < 4000; k++) begin
      if (f ? dma_ready === 1'h0 : q.size() >= n) break;
      @(posedge sys_clk);
    end
    if (k == 4000) begin
      chk("wait", 32'h0, 32'h1);
      results();
    end
  endtask : waitfor
  // Set mode, send one packet, drain it, then read the error status
  task automatic stream(input logic [31:0] c, input logic [7:0] l, k, int n);
    apb(1'h1, gpl_pkg::ADDR_CTRL, c);
    q.delete();
    ants = 0;
    acks = 0;
    @(posedge sys_clk);
    go  <= 1'h1;
    len <= l;
    cut <= k;
    @(posedge sys_clk);
    go <= 1'h0;
    if (!c[1]) waitfor(1'h1, 0); // Link stalled until the FIFO refuses
    run <= 1'h1;
    waitfor(1'h0, n);
    run <= 1'h0;
    for (int i = 0; i < n - (k != 8'h00); i++) begin
      chk("gen_data", q[i].data, 32'ha000_0000 + i);
      chk("gen_delim", q[i].delim_null, c[1] & c[3] & ~c[2]);
    end
    chk("gen_sop", q[0].sop, 1'h1);
    chk("gen_eop", q[n - 1].eop, 1'h1);
    apb(1'h0, gpl_pkg::ADDR_MODSTS, 32'h0);
  endtask : stream
  initial begin
    repeat (6) @(posedge sys_clk);
    chk("ready_rst", dma_ready, 1'h1);
    chk("irq_rst", err_irq, 1'h0);
    resetn <= 1'h1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("reg_rd", r, rows[i].x);
      chk("reg_err", e, rows[i].e);
    end
    // Packet ends count in packet mode; in DIO mode only bursts count
    repeat (3) pulse(23'h1);
    apb(1'h0, gpl_pkg::ADDR_EOP, 32'h0);
    chk("eop_cnt", r, 32'h3);
    apb(1'h1, gpl_pkg::ADDR_CTRL, 32'h20);
    pulse(23'h1);
    repeat (2) pulse(23'h2);
    apb(1'h0, gpl_pkg::ADDR_EOP, 32'h0);
    chk("eop_dio", r, 32'h5);
    // Descriptor starvation, line errors, sync loss, remote module
    for (int i = 2; i < 5; i++) pulse(23'h1 << i);
    pulse(23'h1 << 22);
    apb(1'h0, gpl_pkg::ADDR_MODSTS, 32'h0);
    chk("modsts", r, 32'h38);
    apb(1'h0, gpl_pkg::ADDR_ORIGIN, 32'h0);
    chk("origin", r, 32'h2_0006);
    chk("irq_set", err_irq, 1'h1);
    apb(1'h1, gpl_pkg::ADDR_MODSTS, 32'h3f);
    apb(1'h1, gpl_pkg::ADDR_ORIGIN, 32'h3_ffff);
    repeat (2) @(posedge sys_clk);
    chk("irq_clr", err_irq, 1'h0);
    // CPRI carrier slots shared equally with a busy antenna stream
    ant_valid <= 1'h1;
    stream(32'h5f, 8'h06, 8'h00, 6);
    chk("ant_seen", 32'(ants > 0), 32'h1);
    chk("ant_ack", acks, ants);
    chk("cpri_ok", r, 32'h0);
    ant_valid <= 1'h0;
    // OBSAI control slots with a full FIFO and a stalled link
    stream(32'h41, 8'h0c, 8'h00, 12);
    chk("obsai_ok", r, 32'h0);
    // CPRI control words from row 48, NULL delimited; feed stops mid
    // packet with a wrong symbol index
    sym_expected <= 8'h01;
    stream(32'h300b, 8'h08, 8'h03, 4);
    chk("trunc", q[3].data, 32'h0);
    chk("starve", r, 32'h3);
    chk("irq_enc", err_irq, 1'h1);
    results();
  end
endmodule : gpl_top_tb_top
